/* src/aitc_pkg.sv */
// Purpose: constants, register map and types of the converter trigger control
// Assumes: 40 MHz ref_clk_i, 32-bit Avalon-MM register bus
// Notes:   all offsets are byte addresses of aligned words
//
// Behaviour
// [R01] exactly one of eight inputs reaches the converter, per channel select field
// [R02] codes 1..8: aux one, aux two, current sense, thermistor, junction, backup, bus, cell
// [R03] both aux inputs get bias current 0/10/50/60 uA from wait register field
// [R04] aux input one bias source turns on whenever input power is present
// [R05] reference is internal or external per setup register reference bit
// [R06] external reference selected switches the internal reference regulator off
// [R07] start command begins each conversion; finished word goes to arithmetic unit
// [R08] cycle end copies arithmetic result to result register and updates status
// [R09] internal mode raises next trigger after each conversion, timed by registers
// [R10] third port pin triggers only while external trigger select is set
// [R11] external mode starts conversion only after a pin edge, with programmed timing
// [R12] host starts internal-reference conversions only once reference capacitor charged
// [R13] cycle begins on enable write low to high; host keeps enable set meanwhile
// [R14] samples per cycle follow read mode field, one up to 256
// [R15] external event only on the pin edge matching the edge polarity bit
// [R16] result is an unsigned 10-bit code, full scale 1023 steps
// [R17] one-clock conversion-end pulse to arithmetic unit, separate cycle-end pulse
package aitc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [4:0] OFS_SETUP = 5'h00;
  localparam logic [4:0] OFS_DELAY = 5'h04;
  localparam logic [4:0] OFS_WAIT  = 5'h08;
  localparam logic [4:0] OFS_RES   = 5'h0c;
  localparam logic [4:0] OFS_ISTAT = 5'h10;
  localparam logic [4:0] OFS_IMASK = 5'h14;

  // setup register fields
  localparam int SET_EN_BIT  = 0;
  localparam int SET_REF_BIT = 1;
  localparam int SET_CH_LSB  = 2;
  localparam int SET_RM_LSB  = 6;
  // delay register fields
  localparam int DLY_EXT_BIT = 0;
  localparam int DLY_EDG_BIT = 1;
  localparam int DLY_VAL_LSB = 2;
  // wait register fields
  localparam int WT_VAL_LSB  = 0;
  localparam int WT_B1_LSB   = 4;
  localparam int WT_B2_LSB   = 6;
  // result and interrupt fields
  localparam int RES_BUSY_BIT = 15;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_MISS_BIT = 1;

  // reset values
  localparam logic [15:0] SETUP_RST = 16'h0004;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] WAIT_RST  = 16'h0000;
  localparam logic [3:0]  CH_RST    = 4'h1;
  localparam logic [1:0]  IRQ_RST   = 2'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_KHZ       = 40000;
  localparam int DLY_STEP_NS   = 50000;
  localparam int WAIT_UNIT_NS  = 20000;
  localparam int DLY_STEP_CYC  = (DLY_STEP_NS * CLK_KHZ) / 1000000;
  localparam int WAIT_UNIT_CYC = (WAIT_UNIT_NS * CLK_KHZ) / 1000000;
  localparam int TMR_W         = 20;

  // wait times in units of 20 us, codes 0..15
  localparam logic [10:0] WAIT_MULT [16] = '{
    11'h001, 11'h002, 11'h003, 11'h004, 11'h008, 11'h00c, 11'h010, 11'h020,
    11'h040, 11'h060, 11'h080, 11'h100, 11'h200, 11'h300, 11'h400, 11'h400};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARM   = 3'b001,
    ST_DLY   = 3'b010,
    ST_START = 3'b011,
    ST_CONV  = 3'b100,
    ST_WAIT  = 3'b101,
    ST_FIN   = 3'b110
  } aitc_state_e;

  // samples per cycle: 1, 4, 8 .. 256
  function automatic logic [8:0] aitc_samples(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h001;
    if (code != 3'h0) begin
      n = 9'h001 << ({1'b0, code} + 4'h1); // widened so code 7 gives 256
    end
    return n;
  endfunction

endpackage

/* src/aitc_tmr_if.sv */
// Purpose: load and expiry handshake between control and a down counter
// Assumes: single clock domain
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ps
interface aitc_tmr_if;
  logic                        load;
  logic [aitc_pkg::TMR_W-1:0]  count;
  logic                        expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

/* src/aitc_tmr.sv */
// Purpose: down counter that pulses once a loaded count has elapsed
// Assumes: count 0 expires one cycle after load
// Notes:   a new load restarts the count
`timescale 1ns/1ps
module aitc_tmr
  import aitc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  aitc_tmr_if.tmr   tif
);

  logic [TMR_W-1:0] cnt_q;
  logic             run_q;

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (ce_i) begin
      if (tif.load) begin
        cnt_q <= tif.count;
        run_q <= 1'b1;
      end else if (tif.expired) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // expiry seen from flops only, never during a load
  assign tif.expired = run_q && (cnt_q <= 1) && !tif.load;

endmodule

/* src/aitc_top.sv */
// Purpose: trigger, input selection and register control of a 10-bit converter
// Assumes: converter engine and arithmetic unit sit outside, same clock
// Notes:   arithmetic modes, limits, hold-off and repeat are not handled here
`timescale 1ns/1ps
module aitc_top
  import aitc_pkg::*;
#(
  parameter int DLY_STEP = DLY_STEP_CYC,
  parameter int WAIT_UNIT = WAIT_UNIT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  input  wire logic        input_power_i,
  input  wire logic        third_port_pin_i,
  output logic             conv_start_o,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  output logic      [7:0]  chan_sel_o,
  output logic      [1:0]  aux_one_bias_o,
  output logic      [1:0]  aux_two_bias_o,
  output logic             aux_one_bias_en_o,
  output logic             aux_two_bias_en_o,
  output logic             ref_ext_o,
  output logic             ref_ldo_en_o,
  output logic             alu_cycle_start_o,
  output logic             alu_eoc_o,
  output logic      [9:0]  alu_data_o,
  output logic             alu_eocycle_o,
  input  wire logic [9:0]  alu_result_i
);

  // ****************************************
  // declarations
  // ****************************************
  logic [15:0]  setup_q;
  logic [15:0]  delay_q;
  logic [15:0]  wait_q;
  logic [9:0]   result_q;
  logic [1:0]   istat_q;
  logic [1:0]   imask_q;
  logic         ack_q;
  logic [31:0]  rdata_q;
  logic         wr_go;
  logic [31:0]  wmask;
  logic [15:0]  setup_new;
  logic         en_rise;
  aitc_state_e  state_q;
  aitc_state_e  state_d;
  logic [8:0]   smp_cnt_q;
  logic [8:0]   smp_tgt_q;
  logic [3:0]   ch_act_q;
  logic         ext_q;
  logic         edge_q;
  logic         pin_q;
  logic         pin_edge;
  logic         pin_active;
  logic         ev_done;
  logic         ev_miss;
  logic         busy;

  aitc_tmr_if   dly_if ();
  aitc_tmr_if   wt_if ();

  // ****************************************
  // bus slave
  // ****************************************
  // one wait state so read data come from a flop
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_go             = avs_write_i && ack_q;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign setup_new = (setup_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
  assign avs_readdata_o    = rdata_q;

  // acknowledge toggles so back to back requests each get a wait state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  // read mux, unmapped words read zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_i && avs_read_i && !ack_q) begin
      case (avs_address_i)
        OFS_SETUP: rdata_q <= {16'h0000, setup_q};
        OFS_DELAY: rdata_q <= {16'h0000, delay_q};
        OFS_WAIT:  rdata_q <= {16'h0000, wait_q};
        OFS_RES:   rdata_q <= {16'h0000, busy, 5'h00, result_q}; // [R16]
        OFS_ISTAT: rdata_q <= {30'h0, istat_q};
        OFS_IMASK: rdata_q <= {30'h0, imask_q};
        default:   rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // invalid channel codes keep the old channel so one input always stays routed
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      setup_q <= SETUP_RST;
    end else if (ce_i && wr_go && avs_address_i == OFS_SETUP) begin
      setup_q[SET_CH_LSB-1:0] <= setup_new[SET_CH_LSB-1:0];
      setup_q[15:SET_RM_LSB]  <= setup_new[15:SET_RM_LSB];
      if (setup_new[SET_CH_LSB+:4] >= 4'h1 && setup_new[SET_CH_LSB+:4] <= 4'h8) begin
        setup_q[SET_CH_LSB+:4] <= setup_new[SET_CH_LSB+:4]; // [R01]
      end
    end
  end

  // enable edge seen at the write itself
  assign en_rise = wr_go && avs_address_i == OFS_SETUP
                   && !setup_q[SET_EN_BIT] && setup_new[SET_EN_BIT]; // [R13]

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      delay_q <= DELAY_RST;
    end else if (ce_i && wr_go && avs_address_i == OFS_DELAY) begin
      delay_q <= (delay_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wait_q <= WAIT_RST;
    end else if (ce_i && wr_go && avs_address_i == OFS_WAIT) begin
      wait_q <= (wait_q & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      istat_q <= IRQ_RST;
    end else if (ce_i) begin
      if (wr_go && avs_address_i == OFS_ISTAT && avs_byteenable_i[0]) begin
        istat_q <= (istat_q & ~avs_writedata_i[1:0]) | {ev_miss, ev_done};
      end else begin
        istat_q <= istat_q | {ev_miss, ev_done};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      imask_q <= IRQ_RST;
    end else if (ce_i && wr_go && avs_address_i == OFS_IMASK && avs_byteenable_i[0]) begin
      imask_q <= avs_writedata_i[1:0];
    end
  end

  assign irq_o = |(istat_q & imask_q);

  // ****************************************
  // input selection and reference
  // ****************************************
  // channel follows the register while idle, frozen during a cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ch_act_q <= CH_RST;
    end else if (ce_i && state_q == ST_IDLE) begin
      ch_act_q <= setup_q[SET_CH_LSB+:4];
    end
  end

  // one-hot mux select, code n drives line n-1
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      chan_sel_o <= 8'h01;
    end else if (ce_i) begin
      chan_sel_o <= 8'h01 << (ch_act_q - 4'h1); // [R01] [R02]
    end
  end

  // bias codes: 0 off, 1 10 uA, 2 50 uA, 3 60 uA
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      aux_one_bias_o    <= 2'h0;
      aux_two_bias_o    <= 2'h0;
      aux_one_bias_en_o <= 1'b0;
      aux_two_bias_en_o <= 1'b0;
    end else if (ce_i) begin
      aux_one_bias_o    <= wait_q[WT_B1_LSB+:2]; // [R03]
      aux_two_bias_o    <= wait_q[WT_B2_LSB+:2]; // [R03]
      aux_one_bias_en_o <= input_power_i || (wait_q[WT_B1_LSB+:2] != 2'h0); // [R04]
      aux_two_bias_en_o <= wait_q[WT_B2_LSB+:2] != 2'h0;
    end
  end

  // the regulator stays off whenever an outside reference is chosen
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ref_ext_o    <= 1'b0;
      ref_ldo_en_o <= 1'b1;
    end else if (ce_i) begin
      ref_ext_o    <= setup_q[SET_REF_BIT]; // [R05]
      ref_ldo_en_o <= !setup_q[SET_REF_BIT]; // [R06]
    end
  end

  // ****************************************
  // trigger pin
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
    end else if (ce_i) begin
      pin_q <= third_port_pin_i;
    end
  end

  // edge bit high means rising edge and high active level
  assign pin_edge   = ext_q && (edge_q ? (third_port_pin_i && !pin_q)
                                       : (!third_port_pin_i && pin_q)); // [R10] [R15]
  assign pin_active = (third_port_pin_i == edge_q);

  // ****************************************
  // timers
  // ****************************************
  assign dly_if.load  = (state_q == ST_ARM) && pin_edge;
  assign dly_if.count = TMR_W'(DLY_STEP * int'(delay_q[DLY_VAL_LSB+:4]));
  assign wt_if.load   = (state_q == ST_CONV) && conv_done_i && (smp_cnt_q != smp_tgt_q);
  assign wt_if.count  = TMR_W'(WAIT_UNIT * int'(WAIT_MULT[wait_q[WT_VAL_LSB+:4]]));

  aitc_tmr u_dly (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .tif       (dly_if)
  );

  aitc_tmr u_wait (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .tif       (wt_if)
  );

  // ****************************************
  // trigger controller
  // ****************************************
  // mode bits latched at cycle start; later writes wait for the next cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_q     <= 1'b0;
      edge_q    <= 1'b0;
      smp_tgt_q <= 9'h001;
    end else if (ce_i && state_q == ST_IDLE && en_rise) begin
      ext_q     <= delay_q[DLY_EXT_BIT]; // [R10]
      edge_q    <= delay_q[DLY_EDG_BIT];
      smp_tgt_q <= aitc_samples(setup_q[SET_RM_LSB+:3]); // [R14]
    end
  end

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (en_rise) begin
          state_d = delay_q[DLY_EXT_BIT] ? ST_ARM : ST_START; // [R10] [R13]
        end
      end
      ST_ARM: begin
        if (pin_edge) begin
          state_d = ST_DLY; // [R11]
        end
      end
      ST_DLY: begin
        if (dly_if.expired) begin
          state_d = pin_active ? ST_START : ST_ARM; // [R11]
        end
      end
      ST_START: begin
        state_d = ST_CONV;
      end
      ST_CONV: begin
        if (conv_done_i) begin
          state_d = (smp_cnt_q == smp_tgt_q) ? ST_FIN : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wt_if.expired) begin
          state_d = ST_START; // [R09]
        end
      end
      ST_FIN: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // sample counter, counts conversions started in this cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      smp_cnt_q <= 9'h000;
    end else if (ce_i) begin
      if (state_q == ST_IDLE) begin
        smp_cnt_q <= 9'h000;
      end else if (state_q == ST_START) begin
        smp_cnt_q <= smp_cnt_q + 9'h001;
      end
    end
  end

  // start pulse for the converter and first-sample marker for the arithmetic unit
  assign conv_start_o      = (state_q == ST_START); // [R07]
  assign alu_cycle_start_o = (state_q == ST_START) && (smp_cnt_q == 9'h000);
  assign busy              = (state_q != ST_IDLE);

  // converter word handed on with a one-clock strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      alu_eoc_o  <= 1'b0;
      alu_data_o <= 10'h000;
    end else if (ce_i) begin
      alu_eoc_o <= (state_q == ST_CONV) && conv_done_i; // [R07] [R17]
      if (state_q == ST_CONV && conv_done_i) begin
        alu_data_o <= conv_data_i; // [R16]
      end
    end
  end

  // arithmetic unit gets no extra clock: its result is taken at the end of the cycle of the last strobe
  assign alu_eocycle_o = (state_q == ST_FIN); // [R17]
  assign ev_done       = (state_q == ST_FIN) && ce_i;
  assign ev_miss       = (state_q == ST_DLY) && dly_if.expired && !pin_active && ce_i;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      result_q <= 10'h000;
    end else if (ce_i && state_q == ST_FIN) begin
      result_q <= alu_result_i; // [R08]
    end
  end

endmodule

/* verification/aitc_conv_model.sv */
// Purpose: converter engine and pass-through arithmetic unit beside aitc_top
// Assumes: one clock, start pulses only while the engine is idle
// Notes:   latency and data word are set by the bench per run
`timescale 1ns/1ps
module aitc_conv_model
  import aitc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [3:0] lat_i,
  input  wire logic [9:0] base_i,
  input  wire logic [9:0] alu_data_i,
  output logic            done_o,
  output logic      [9:0] data_o,
  output logic      [9:0] alu_result_o
);
  logic [3:0] cnt_q;
  logic       busy_q;

  // ********
  // engine
  // ********
  // one conversion per start, done pulse lat_i + 2 cycles after the start pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_q <= 1'b1;
        cnt_q  <= lat_i;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done_o <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // word valid only with done; inverted otherwise so stale data is caught
  assign data_o       = done_o ? base_i : ~base_i;
  // no-processing mode: accumulator takes the engine word unchanged
  assign alu_result_o = alu_data_i;
endmodule

/* verification/aitc_chk.sv */
// Purpose: port-level assertions on aitc_top
// Assumes: single clock domain, sync active-low reset
// Notes:   bound to every aitc_top instance
`timescale 1ns/1ps
module aitc_chk (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       input_power_i,
  input wire logic [7:0] chan_sel_o,
  input wire logic [1:0] aux_two_bias_o,
  input wire logic       aux_one_bias_en_o,
  input wire logic       aux_two_bias_en_o,
  input wire logic       ref_ext_o,
  input wire logic       ref_ldo_en_o,
  input wire logic       conv_start_o,
  input wire logic       conv_done_i,
  input wire logic [9:0] conv_data_i,
  input wire logic       alu_cycle_start_o,
  input wire logic       alu_eoc_o,
  input wire logic [9:0] alu_data_o,
  input wire logic       alu_eocycle_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ********
  // register bus
  // ********
  a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  a_bus_idle: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
    else $error("waitrequest without request");

  // ********
  // input selection and reference
  // ********
  a_chan_onehot: assert property ($onehot(chan_sel_o))
    else $error("mux select not one-hot");
  a_ref_excl: assert property (ref_ext_o != ref_ldo_en_o)
    else $error("reference regulator state wrong");
  a_bias_two: assert property (aux_two_bias_en_o == (aux_two_bias_o != 2'h0))
    else $error("aux two bias enable wrong");
  a_bias_power: assert property (input_power_i |=> aux_one_bias_en_o)
    else $error("aux one bias off with power");

  // ********
  // trigger control
  // ********
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  a_cyc_start: assert property (alu_cycle_start_o |-> conv_start_o)
    else $error("cycle start without start");
  a_eoc_cause: assert property (alu_eoc_o |-> $past(conv_done_i) && !$past(alu_eoc_o))
    else $error("eoc not one cycle after done");
  a_eoc_data: assert property (alu_eoc_o |-> alu_data_o == $past(conv_data_i))
    else $error("word to unit differs");
  a_cycle_end: assert property (alu_eocycle_o |-> alu_eoc_o ##1 !alu_eocycle_o)
    else $error("cycle end pulse wrong");
endmodule

bind aitc_top aitc_chk aitc_chk_inst (.ref_clk_i, .rst_n_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .input_power_i, .chan_sel_o, .aux_two_bias_o, .aux_one_bias_en_o,
  .aux_two_bias_en_o, .ref_ext_o, .ref_ldo_en_o, .conv_start_o, .conv_done_i,
  .conv_data_i, .alu_cycle_start_o, .alu_eoc_o, .alu_data_o, .alu_eocycle_o);

/* verification/tb.sv */
// Purpose: self-checking bench for aitc_top over its register bus
// Assumes: short timer steps, engine model with per-run latency
// Notes:   bus tasks hold each request until waitrequest is seen low
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  import aitc_pkg::*;
  logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, input_power_i = 1'b0;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0, third_port_pin_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i = 4'hf, lat = 4'h0;
  logic        avs_waitrequest_o, irq_o, conv_start_o, conv_done_i, aux_one_bias_en_o;
  logic        aux_two_bias_en_o, ref_ext_o, ref_ldo_en_o, alu_cycle_start_o, alu_eoc_o;
  logic        alu_eocycle_o;
  logic [9:0]  conv_data_i, alu_data_o, alu_result_i, base = 10'h000;
  logic [7:0]  chan_sel_o;
  logic [1:0]  aux_one_bias_o, aux_two_bias_o;
  int          miscompares = 0, n_checks = 0, n_starts = 0, s0 = 0;

  // small steps keep delay and wait timers short
  aitc_top #(.DLY_STEP(3), .WAIT_UNIT(2)) aitc_top_inst (.ref_clk_i, .rst_n_i, .ce_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .irq_o, .input_power_i, .third_port_pin_i,
    .conv_start_o, .conv_done_i, .conv_data_i, .chan_sel_o, .aux_one_bias_o,
    .aux_two_bias_o, .aux_one_bias_en_o, .aux_two_bias_en_o, .ref_ext_o, .ref_ldo_en_o,
    .alu_cycle_start_o, .alu_eoc_o, .alu_data_o, .alu_eocycle_o, .alu_result_i);
  aitc_conv_model aitc_conv_model_inst (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .start_i(conv_start_o), .lat_i(lat), .base_i(base), .alu_data_i(alu_data_o),
    .done_o(conv_done_i), .data_o(conv_data_i), .alu_result_o(alu_result_i));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // start pulses counted independently of the design's status
  always @(posedge ref_clk_i) begin
    if (conv_start_o === 1'b1) n_starts++;
  end

  // ********
  // tasks
  // ********
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one access; called just after a rising edge, returns once outputs settled
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    // registered outputs trail a write by two edges
    repeat (3) @(posedge ref_clk_i);
    if (i == 40) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask
  // enable goes low then high to open a cycle
  task automatic arm(input logic [31:0] s);
    s0 = n_starts;
    bus(1'b1, OFS_SETUP, s);
    bus(1'b1, OFS_SETUP, s | 32'h1);
  endtask
  task automatic done_chk(input int nexp);
    int i;
    for (i = 0; i < 3000; i++) begin
      bus(1'b0, OFS_RES, 32'h0);
      if (q[RES_BUSY_BIT] === 1'b0) break;
    end
    if (i == 3000) begin
      miscompares++;
      final_report();
    end
    `CHK("starts", nexp, n_starts - s0)
    `CHK("result", {6'h00, base}, q[15:0])
  endtask
  // armed external trigger: level alone and wrong edge do not start, nor, with a nonzero delay, a short pulse
  task automatic ext(input logic e, input logic [3:0] d);
    third_port_pin_i <= e;
    bus(1'b1, OFS_DELAY, {26'h0, d, e, 1'b1});
    arm(32'h5 << SET_CH_LSB);
    repeat (20) @(posedge ref_clk_i);
    third_port_pin_i <= !e;
    repeat (20) @(posedge ref_clk_i);
    `CHK("level or wrong edge", 0, n_starts - s0)
    if (d != 4'h0) begin
      third_port_pin_i <= e;
      repeat (2) @(posedge ref_clk_i);
      third_port_pin_i <= !e;
      repeat (3 * d + 10) @(posedge ref_clk_i);
      `CHK("short pulse", 0, n_starts - s0)
      chk_rd(OFS_ISTAT, 32'h2, "missed");
    end
    third_port_pin_i <= e;
    done_chk(1);
    bus(1'b1, OFS_ISTAT, 32'h3);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk_rd(OFS_SETUP, {16'h0, SETUP_RST}, "setup");
    for (int k = 1; k < 6; k++) chk_rd(5'(4 * k), 32'h0, "zero reg");
    `CHK("ldo", 1'b1, ref_ldo_en_o)
    bus(1'b1, OFS_RES, 32'h3ff);
    chk_rd(OFS_RES, 32'h0, "result ro");
    // code 9 is not a channel, the last one stays
    for (int c = 1; c <= 9; c++) begin
      bus(1'b1, OFS_SETUP, 32'(c) << SET_CH_LSB);
      `CHK("chan", (c == 9) ? 8'h80 : 8'h01 << (c - 1), chan_sel_o)
    end
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, OFS_WAIT, 32'(b) << WT_B1_LSB | 32'(3 - b) << WT_B2_LSB);
      `CHK("bias1", 2'(b), aux_one_bias_o)
      `CHK("bias2", 2'(3 - b), aux_two_bias_o)
      `CHK("bias1 en", b != 0, aux_one_bias_en_o)
    end
    bus(1'b1, OFS_WAIT, 32'h0);
    input_power_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    `CHK("power bias", 1'b1, aux_one_bias_en_o)
    bus(1'b1, OFS_SETUP, 32'h22);
    `CHK("ext ref", 2'b10, {ref_ext_o, ref_ldo_en_o})
    bus(1'b1, OFS_SETUP, 32'h20);
    repeat (20) @(posedge ref_clk_i); // reference capacitor charges first
    bus(1'b1, OFS_IMASK, 32'h1);
    for (int m = 0; m < 8; m++) begin
      lat  <= 4'(m);
      base <= 10'h3ff - 10'(m);
      arm(32'(m) << SET_RM_LSB | 32'h1c);
      done_chk(m == 0 ? 1 : 2 << m);
    end
    `CHK("irq", 1'b1, irq_o)
    bus(1'b1, OFS_ISTAT, 32'h1);
    `CHK("irq clr", 1'b0, irq_o)
    bus(1'b1, OFS_IMASK, 32'h0);
    arm(32'h1c);
    done_chk(1);
    `CHK("irq masked", 1'b0, irq_o)
    chk_rd(OFS_ISTAT, 32'h1, "done flag");
    bus(1'b1, OFS_ISTAT, 32'h1);
    ext(1'b1, 4'h3);
    ext(1'b0, 4'h2);
    ext(1'b1, 4'h0);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    miscompares++;
    final_report();
  end
endmodule
